// ### i2c_monitor_qualifier_rate.sv
// I2C bus monitor with optional SCL stretching, slave address-0 qualifier and SCL rate generator.
// Assumes SCL and SDA pins arrive asynchronously; open-drain pad outside.
module i2c_monitor_qualifier_rate
  import i2c_mqr_pkg::*;
#(
  parameter int DIV_W = 16, // Width of the function clock divider
  parameter int TIME_W = 4 // Width of each SCL count field
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [31:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic [ADR_COUNT-1:0] slave_match,
  output logic irq
);
  localparam int PH_W = TIME_W + 1; // Phase counter holds count + 2

  // Register state
  logic [2:0] cfg_reg; // Run, monitor enable, stretch enable
  logic [DIV_W-1:0] div_reg; // Function clock divider
  logic [2*TIME_W-1:0] time_reg; // High count above low count
  logic [ADR_COUNT-1:0] adr_dis_reg; // Per-comparator disable
  logic [6:0] adr_reg [ADR_COUNT]; // Seven-bit slave addresses
  logic qual_mode_reg; // Range mode when set
  logic [6:0] qual_reg; // Mask or upper bound
  logic [EV_W-1:0] istat_reg; // Sticky events
  logic [EV_W-1:0] imask_reg; // Event mask
  logic [31:0] rdata_reg; // Read data, valid one cycle after rd
  // Pin synchronisers and edge history
  logic scl_m, scl_s, scl_d; // Meta, stable, delayed
  logic sda_m, sda_s, sda_d;
  // Monitor state
  logic busy_reg; // Between start and stop
  logic start_pend_reg; // Next entry follows a start
  logic restart_pend_reg; // Next entry follows a repeated start
  logic addr_phase_reg; // Next entry is an address byte
  logic [3:0] bit_cnt_reg; // Bits of the current entry seen
  logic [7:0] shift_reg; // Incoming byte
  logic [10:0] mon_reg; // Reported entry
  logic mon_valid_reg; // Entry not yet read
  logic stretch_reg; // Monitor holds SCL low
  logic [ADR_COUNT-1:0] match_reg; // Registered comparator results
  // Clock generator state
  mst_state_t mst_state;
  logic [DIV_W-1:0] pre_reg; // Prescaler within one tick
  logic [PH_W-1:0] ph_reg; // Ticks elapsed in the phase
  logic oe_reg;
  logic irq_reg;

  // Bus events seen on synchronised pins
  logic scl_rise, start_ev, stop_ev, entry_done, addr_done, mon_rd, ist_rd;
  logic [TIME_W-1:0] hi_cnt, lo_cnt;
  logic tick, lo_done, hi_done, high_cut;
  logic [EV_W-1:0] ev_set;
  assign scl_rise = scl_s & ~scl_d;
  assign start_ev = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_ev = scl_s & scl_d & ~sda_d & sda_s;
  assign entry_done = busy_reg & scl_rise & (bit_cnt_reg == ACK_BIT);
  assign addr_done = entry_done & addr_phase_reg;
  assign mon_rd = rd & (addr == MON_OFF);
  assign ist_rd = rd & (addr == ISTAT_OFF);
  assign hi_cnt = time_reg[TIME_HI_LSB +: TIME_W];
  assign lo_cnt = time_reg[TIME_W-1:0];
  // One tick per (divider + 1) function clocks; rate follows from it
  assign tick = (pre_reg == div_reg);
  assign lo_done = tick & (ph_reg == PH_W'(lo_cnt) + PH_W'(1));
  assign hi_done = tick & (ph_reg == PH_W'(hi_cnt) + PH_W'(1));
  // Another master pulling SCL low ends our high phase early
  assign high_cut = (mst_state == M_HIGH) & ~scl_s;

  // Comparator n: disabled never hits, address 0 qualified
  function automatic logic addr_hit(input int n, input logic [6:0] rx);
    logic hit;
    hit = 1'b0;
    if (adr_dis_reg[n]) begin
      hit = 1'b0;
    end else if (n != 0) begin
      hit = (rx == adr_reg[n]);
    end else if (qual_mode_reg) begin
      hit = (rx >= adr_reg[0]) && (rx <= qual_reg);
    end else begin
      // Zero mask degenerates to an exact compare
      hit = ((rx ^ adr_reg[0]) & ~qual_reg) == 7'h00;
    end
    return hit;
  endfunction : addr_hit

  // Two-stage synchronisers, then one history stage for edges
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      {scl_m, scl_s, scl_d} <= 3'h7;
      {sda_m, sda_s, sda_d} <= 3'h7;
    end else begin
      scl_m <= scl_in;
      scl_s <= scl_m;
      scl_d <= scl_s;
      sda_m <= sda_in;
      sda_s <= sda_m;
      sda_d <= sda_s;
    end
  end

  // Software-written registers; reserved bits are simply not stored
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cfg_reg <= 3'h0;
      div_reg <= '0;
      time_reg <= '0;
      adr_dis_reg <= {ADR_COUNT{ADR_DIS_RST}};
      qual_mode_reg <= 1'b0;
      qual_reg <= QUAL_RST;
      imask_reg <= '0;
      for (int i = 0; i < ADR_COUNT; i++) begin
        adr_reg[i] <= ADR_RST;
      end
    end else if (wr) begin
      // Reserved bits above each field are dropped
      case (addr)
        CFG_OFF: cfg_reg <= wdata[2:0];
        DIV_OFF: div_reg <= wdata[DIV_W-1:0];
        TIME_OFF: time_reg <= wdata[2*TIME_W-1:0];
        QUAL_OFF: begin
          qual_mode_reg <= wdata[0];
          qual_reg <= wdata[7:1];
        end
        IMASK_OFF: imask_reg <= wdata[EV_W-1:0];
        default: begin
          // Slave address words sit one after another
          for (int i = 0; i < ADR_COUNT; i++) begin
            if (addr == ADR0_OFF + 32'(4 * i)) begin
              adr_dis_reg[i] <= wdata[0];
              adr_reg[i] <= wdata[7:1];
            end
          end
        end
      endcase
    end
  end

  // Read mux; unmapped and reserved bits read as zero
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata_reg <= '0;
    end else if (rd) begin
      rdata_reg <= '0;
      case (addr)
        CFG_OFF: rdata_reg[2:0] <= cfg_reg;
        DIV_OFF: rdata_reg[DIV_W-1:0] <= div_reg;
        TIME_OFF: rdata_reg[2*TIME_W-1:0] <= time_reg;
        QUAL_OFF: rdata_reg[7:0] <= {qual_reg, qual_mode_reg};
        ISTAT_OFF: rdata_reg[EV_W-1:0] <= istat_reg;
        IMASK_OFF: rdata_reg[EV_W-1:0] <= imask_reg;
        MON_OFF: rdata_reg[10:0] <= mon_reg;
        default: begin
          for (int i = 0; i < ADR_COUNT; i++) begin
            if (addr == ADR0_OFF + 32'(4 * i)) begin
              rdata_reg[7:0] <= {adr_reg[i], adr_dis_reg[i]};
            end
          end
        end
      endcase
    end
  end

  // Bit framing: start and stop resynchronise, SCL rise samples SDA
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      busy_reg <= 1'b0;
      start_pend_reg <= 1'b0;
      restart_pend_reg <= 1'b0;
      addr_phase_reg <= 1'b0;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
    end else if (start_ev) begin
      // A start while busy is a repeated start
      busy_reg <= 1'b1;
      start_pend_reg <= ~busy_reg;
      restart_pend_reg <= busy_reg;
      addr_phase_reg <= 1'b1;
      bit_cnt_reg <= 4'h0;
    end else if (stop_ev) begin
      busy_reg <= 1'b0;
      bit_cnt_reg <= 4'h0;
    end else if (busy_reg && scl_rise) begin
      if (bit_cnt_reg < BYTE_BITS) begin
        shift_reg <= {shift_reg[6:0], sda_s};
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
      end else begin
        // Acknowledge bit closes the entry; flags belong to it alone
        bit_cnt_reg <= 4'h0;
        start_pend_reg <= 1'b0;
        restart_pend_reg <= 1'b0;
        addr_phase_reg <= 1'b0;
      end
    end
  end

  // Reported entry: replaced only when the next one has fully arrived
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mon_reg <= MON_RST;
    end else if (entry_done && cfg_reg[CFG_MONITOR_ENABLE_BIT]) begin
      mon_reg <= {sda_s, restart_pend_reg, start_pend_reg, shift_reg};
    end
  end

  // Unread marker; a fresh entry beats a same-cycle read
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mon_valid_reg <= 1'b0;
    end else if (entry_done && cfg_reg[CFG_MONITOR_ENABLE_BIT]) begin
      mon_valid_reg <= 1'b1;
    end else if (mon_rd || !cfg_reg[CFG_MONITOR_ENABLE_BIT]) begin
      mon_valid_reg <= 1'b0;
    end
  end

  // Hold SCL low in the acknowledge low phase while the entry is unread;
  // this delays the acknowledge clock, the edge that would overwrite it
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stretch_reg <= 1'b0;
    end else begin
      stretch_reg <= cfg_reg[CFG_STR] & cfg_reg[CFG_MONITOR_ENABLE_BIT] & busy_reg &
                     ~scl_s & (bit_cnt_reg == ACK_BIT) &
                     mon_valid_reg & ~mon_rd;
    end
  end

  // Address comparators sampled at each address entry, cleared by stop
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      match_reg <= '0;
    end else if (addr_done) begin
      for (int i = 0; i < ADR_COUNT; i++) begin
        match_reg[i] <= addr_hit(i, shift_reg[7:1]);
      end
    end else if (stop_ev) begin
      match_reg <= '0;
    end
  end

  // Master clock generator: low, release, wait for the wire, high
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mst_state <= M_IDLE;
      pre_reg <= '0;
      ph_reg <= '0;
    end else begin
      pre_reg <= tick ? '0 : pre_reg + DIV_W'(1);
      if (tick) begin
        ph_reg <= ph_reg + PH_W'(1);
      end
      case (mst_state)
        M_IDLE: begin
          if (cfg_reg[CFG_RUN]) begin
            mst_state <= M_LOW;
            pre_reg <= '0;
            ph_reg <= '0;
          end
        end
        M_LOW: begin
          if (lo_done) begin
            mst_state <= M_WAITHI;
          end
        end
        M_WAITHI: begin
          // Other devices may stretch; high time counts from the rise
          if (!cfg_reg[CFG_RUN]) begin
            mst_state <= M_IDLE;
          end else if (scl_s) begin
            mst_state <= M_HIGH;
            pre_reg <= '0;
            ph_reg <= '0;
          end
        end
        M_HIGH: begin
          if (!cfg_reg[CFG_RUN]) begin
            mst_state <= M_IDLE;
          end else if (hi_done || high_cut) begin
            mst_state <= M_LOW;
            pre_reg <= '0;
            ph_reg <= '0;
          end
        end
        default: mst_state <= M_IDLE;
      endcase
    end
  end

  // SCL drive: master low phase or monitor stretch; SDA never driven
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      oe_reg <= 1'b0;
    end else begin
      oe_reg <= (mst_state == M_LOW) | stretch_reg;
    end
  end

  // Sticky events, set wins over the clearing read
  assign ev_set[EV_MON] = entry_done & cfg_reg[CFG_MONITOR_ENABLE_BIT];
  assign ev_set[EV_OVR] = ev_set[EV_MON] & mon_valid_reg & ~mon_rd;
  assign ev_set[EV_MATCH] = addr_done;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      istat_reg <= '0;
      irq_reg <= 1'b0;
    end else begin
      istat_reg <= (ist_rd ? '0 : istat_reg) | ev_set;
      irq_reg <= |(((ist_rd ? '0 : istat_reg) | ev_set) & imask_reg);
    end
  end

  assign rdata = rdata_reg;
  assign scl_out = 1'b0; // Open drain: only ever pulls low
  assign scl_oe = oe_reg;
  assign sda_out = 1'b0;
  assign sda_oe = 1'b0; // Monitor is passive on data
  assign slave_match = match_reg;
  assign irq = irq_reg;

  // Checking helpers: cycles spent in the current master phase
  logic [31:0] ph_cyc;
  logic [31:0] hi_need, lo_need;
  assign hi_need = (32'(div_reg) + 32'd1) * (32'(hi_cnt) + 32'd2);
  assign lo_need = (32'(div_reg) + 32'd1) * (32'(lo_cnt) + 32'd2);
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ph_cyc <= '0;
    end else if (mst_state != $past(mst_state)) begin
      ph_cyc <= 32'd1;
    end else begin
      ph_cyc <= ph_cyc + 32'd1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  chk_mask_match: assert property (
    addr_done && !qual_mode_reg && !adr_dis_reg[0] &&
    (((shift_reg[7:1] ^ adr_reg[0]) & ~qual_reg) == 7'h00)
    |=> slave_match[0])
    else $error("masked address 0 failed to match");
  chk_range_match: assert property (
    addr_done && qual_mode_reg && !adr_dis_reg[0]
    |=> slave_match[0] == ($past(shift_reg[7:1]) >= $past(adr_reg[0]) &&
                           $past(shift_reg[7:1]) <= $past(qual_reg)))
    else $error("range match wrong");
  chk_exact_zero: assert property (
    addr_done && !qual_mode_reg && qual_reg == 7'h00 && !adr_dis_reg[0]
    |=> slave_match[0] == ($past(shift_reg[7:1]) == $past(adr_reg[0])))
    else $error("zero qualifier not exact");
  chk_disabled_quiet: assert property (
    addr_done && adr_dis_reg[1] |=> !slave_match[1])
    else $error("disabled comparator matched");
  chk_disabled_zero: assert property (
    addr_done && adr_dis_reg[0] |=> !slave_match[0])
    else $error("disabled address 0 matched");
  chk_entry_capture: assert property (
    entry_done && cfg_reg[CFG_MONITOR_ENABLE_BIT]
    |=> mon_reg[7:0] == $past(shift_reg) && mon_reg[MON_NACK] == $past(sda_s))
    else $error("monitor entry not captured");
  chk_start_flags: assert property (
    start_ev && !busy_reg ##1 (!start_ev && !stop_ev)[*1] ##0
    (bit_cnt_reg == 4'h0)
    |-> start_pend_reg && !restart_pend_reg)
    else $error("start flag wrong");
  chk_monitor_gate: assert property (
    !entry_done || !cfg_reg[CFG_MONITOR_ENABLE_BIT] |=> $stable(mon_reg))
    else $error("monitor entry changed without capture");
  chk_stretch_hold: assert property (
    stretch_reg |=> scl_oe)
    else $error("stretch not driving SCL");
  chk_sda_passive: assert property (
    !sda_oe) else $error("SDA driven");
  // The cycle that ends at the leaving edge is not yet in ph_cyc
  chk_high_time: assert property (
    mst_state == M_HIGH && hi_done |-> ph_cyc + 32'd1 == hi_need)
    else $error("SCL high time wrong");
  chk_low_time: assert property (
    mst_state == M_LOW && lo_done |-> ph_cyc + 32'd1 == lo_need)
    else $error("SCL low time wrong");
  chk_high_cut: assert property (
    high_cut && cfg_reg[CFG_RUN] |=> mst_state == M_LOW)
    else $error("high phase not cut short");

  cov_restart: cover property (entry_done && restart_pend_reg);
  cov_stretch: cover property (stretch_reg ##1 !stretch_reg);
  cov_range_hit: cover property (addr_done && qual_mode_reg ##1 slave_match[0]);
  cov_cut: cover property (high_cut && cfg_reg[CFG_RUN]);
endmodule : i2c_monitor_qualifier_rate

// ### i2c_mqr_pkg.sv
// Constants shared by the I2C monitor, address qualifier and rate logic.
// Assumes a 32-bit register port that decodes full byte addresses.
package i2c_mqr_pkg;
  // Register byte addresses
  localparam logic [31:0] CFG_OFF = 32'h4005_0000; // Run and monitor enables
  localparam logic [31:0] DIV_OFF = 32'h4005_0014; // Function clock divider
  localparam logic [31:0] TIME_OFF = 32'h4005_0024; // SCL low/high counts
  localparam logic [31:0] ADR0_OFF = 32'h4005_0048; // First slave address
  localparam logic [31:0] QUAL_OFF = 32'h4005_0058; // Address-0 qualifier
  localparam logic [31:0] ISTAT_OFF = 32'h4005_0060; // Sticky events
  localparam logic [31:0] IMASK_OFF = 32'h4005_0064; // Event mask
  localparam logic [31:0] MON_OFF = 32'h4005_0080; // Monitor capture
  // Configuration bit positions
  localparam int CFG_RUN = 0; // Master clock generator runs
  localparam int CFG_MONITOR_ENABLE_BIT = 1; // Monitor enable
  localparam int CFG_STR = 2; // Monitor clock stretching
  // Field positions
  localparam int TIME_HI_LSB = 4; // High count sits above low count
  localparam int MON_START = 8; // Start seen
  localparam int MON_RESTART = 9; // Repeated start seen
  localparam int MON_NACK = 10; // Not acknowledged
  // Event bits
  localparam int EV_MON = 0; // Monitor entry ready
  localparam int EV_OVR = 1; // Unread entry overwritten
  localparam int EV_MATCH = 2; // Address byte received, matched or not
  localparam int EV_W = 3; // Number of events
  // Reset values
  localparam logic ADR_DIS_RST = 1'b1; // Addresses start disabled
  localparam logic [6:0] ADR_RST = 7'h00;
  localparam logic [6:0] QUAL_RST = 7'h00;
  localparam logic [10:0] MON_RST = 11'h000;
  // Bit counting
  localparam logic [3:0] ACK_BIT = 4'h8; // Index of the acknowledge bit
  localparam logic [3:0] BYTE_BITS = 4'h8; // Data bits in a byte
  localparam logic [3:0] ENTRY_BITS = 4'h9; // Data bits plus acknowledge
  localparam int ADR_COUNT = 4; // Slave address comparators
  // Clock generator states, Gray along low, wait, high
  typedef enum logic [1:0] {
    M_IDLE = 2'b00,
    M_LOW = 2'b01,
    M_WAITHI = 2'b11,
    M_HIGH = 2'b10
  } mst_state_t;
endpackage : i2c_mqr_pkg

// ### i2c_bus_model.sv
// Behavioural I2C master plus receivers on the open-drain SCL and SDA lines.
// Assumes pull-ups outside, so a released line reads high.
module i2c_bus_model (
  input wire logic clk,
  input wire logic scl_line,
  output logic scl_low,
  output logic sda_low
);
  int n_to = 0; // Stretch waits that ran out
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  // Wait a number of function clocks
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  // Release SCL, then wait while anyone still holds it low (bounded)
  task automatic rel_scl();
    int k;
    scl_low <= 1'b0;
    for (k = 0; k < 2000 && scl_line !== 1'b1; k++) @(posedge clk);
    if (k == 2000) n_to++;
    tick(5);
  endtask : rel_scl
  // One bit: SDA changes only while SCL is low
  task automatic put_bit(input logic b);
    @(posedge clk) sda_low <= ~b;
    tick(4);
    rel_scl();
    scl_low <= 1'b1;
    tick(5);
  endtask : put_bit
  // Start or repeated start: SDA falls while SCL is high
  task automatic start_cond();
    @(posedge clk) sda_low <= 1'b0;
    tick(4);
    rel_scl();
    sda_low <= 1'b1;
    tick(5);
    scl_low <= 1'b1;
    tick(5);
  endtask : start_cond
  // Eight bits MSB first, then the receivers' acknowledge
  task automatic send_byte(input logic [7:0] d, input logic ack);
    for (int i = 7; i >= 0; i--) put_bit(d[i]);
    put_bit(~ack);
  endtask : send_byte
  // Another device holds SCL low for n clocks, cutting a high phase
  task automatic hold_scl(input int n);
    scl_low <= 1'b1;
    tick(n);
    scl_low <= 1'b0;
  endtask : hold_scl
  // Stop: SDA rises while SCL is high, then both lines are released
  task automatic stop_cond();
    @(posedge clk) sda_low <= 1'b1;
    tick(4);
    rel_scl();
    sda_low <= 1'b0;
    tick(5);
  endtask : stop_cond
endmodule : i2c_bus_model

// ### i2c_monitor_qualifier_rate_tb.sv
// Self-checking bench for the monitor, address-0 qualifier and SCL rate.
// Assumes the bus model above as the only other party on SCL and SDA.
module i2c_monitor_qualifier_rate_tb
  import i2c_mqr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [31:0] addr = 32'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic scl_out, scl_oe, sda_out, sda_oe, irq;
  logic [ADR_COUNT-1:0] slave_match;
  logic scl_low, sda_low;
  int n_errors = 0;
  int num_checks = 0;
  // Wired-AND of the open-drain lines, pull-ups when released
  wire logic scl_line = ~(scl_oe | scl_low);
  wire logic sda_line = ~(sda_oe | sda_low);
  always #10 clk = ~clk; // 50 MHz
  i2c_monitor_qualifier_rate uut (.clk(clk), .rstn(rstn), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .scl_in(scl_line),
    .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .slave_match(slave_match),
    .irq(irq));
  i2c_bus_model bus (.clk(clk), .scl_line(scl_line), .scl_low(scl_low),
    .sda_low(sda_low));
  // Verdict, reached from the main sequence and from the wait_oe timeout
  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test
  // Single compare for register values and flags alike
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t got %h want %h", $time, got, exp);
    end
  endtask : cmp
  // One-cycle write strobe; reserved bits always sent as zero
  task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  // One-cycle read strobe; data taken in the following cycle only
  task automatic rd_reg(input logic [31:0] a, output logic [31:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg
  task automatic chk_rd(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd_reg(a, d);
    cmp(d, exp);
  endtask : chk_rd
  // Bounded wait for the stretch or master drive to reach a level
  task automatic wait_oe(input logic v);
    int k;
    for (k = 0; k < 1000 && scl_oe !== v; k++) begin
      @(posedge clk);
      #1;
    end
    if (k == 1000) begin
      n_errors++;
      $display("MISMATCH %0t SCL drive wait ran out", $time);
      end_of_test();
    end
  endtask : wait_oe
  // Reset values, unmapped address, idle interrupt
  task automatic t_reset();
    chk_rd(QUAL_OFF, 32'h0);
    chk_rd(ADR0_OFF, 32'h1);
    chk_rd(MON_OFF, 32'h0);
    chk_rd(32'h4005_0100, 32'h0);
    cmp(irq, 1'b0);
  endtask : t_reset
  // Traffic with the monitor off leaves the capture empty
  task automatic t_disabled();
    bus.start_cond();
    bus.send_byte(8'h5a, 1'b1);
    bus.stop_cond();
    chk_rd(MON_OFF, 32'h0);
    cmp(sda_oe, 1'b0);
    cmp({scl_out, sda_out}, 2'b00);
  endtask : t_disabled
  // Start, data, repeated start with nack; interrupt raise, clear, mask
  task automatic t_flags();
    logic [31:0] d;
    wr_reg(CFG_OFF, 32'h2);
    wr_reg(IMASK_OFF, 32'h1);
    rd_reg(ISTAT_OFF, d);
    bus.start_cond();
    bus.send_byte(8'h54, 1'b1);
    cmp(irq, 1'b1);
    chk_rd(MON_OFF, 32'h154);
    chk_rd(ISTAT_OFF, 32'h5);
    bus.tick(2);
    cmp(irq, 1'b0);
    bus.send_byte(8'h33, 1'b1);
    chk_rd(MON_OFF, 32'h033);
    bus.start_cond();
    bus.send_byte(8'ha5, 1'b0);
    chk_rd(MON_OFF, 32'h6a5);
    bus.stop_cond();
    wr_reg(IMASK_OFF, 32'h0);
    rd_reg(ISTAT_OFF, d);
    bus.start_cond();
    bus.send_byte(8'h11, 1'b1);
    bus.stop_cond();
    cmp(irq, 1'b0);
    // Monitor entry plus address-byte event
    chk_rd(ISTAT_OFF, 32'h5);
  endtask : t_flags
  // Mask, range, exact and disabled address-0 compares from a table
  task automatic t_qual();
    logic [7:0] adr[8] = '{8'h40, 8'h40, 8'h20, 8'h20, 8'h20, 8'h40,
      8'h40, 8'h41};
    logic [7:0] qv[8] = '{8'h06, 8'h06, 8'h29, 8'h29, 8'h29, 8'h00,
      8'h00, 8'h00};
    logic [6:0] rx[8] = '{7'h23, 7'h27, 7'h14, 7'h10, 7'h15, 7'h20,
      7'h21, 7'h20};
    logic hit[8] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
    for (int i = 0; i < 8; i++) begin
      wr_reg(ADR0_OFF, {24'h0, adr[i]});
      wr_reg(QUAL_OFF, {24'h0, qv[i]});
      bus.start_cond();
      bus.send_byte({rx[i], 1'b0}, 1'b1);
      cmp(slave_match[0], hit[i]);
      cmp(slave_match[3:1], 3'h0);
      bus.stop_cond();
    end
  endtask : t_qual
  // Unread entry plus a full next byte makes the monitor hold SCL low
  task automatic t_stretch();
    logic [31:0] d;
    wr_reg(CFG_OFF, 32'h6);
    rd_reg(MON_OFF, d);
    bus.start_cond();
    bus.send_byte(8'h3c, 1'b1);
    fork
      bus.send_byte(8'hc3, 1'b1);
      begin
        wait_oe(1'b1);
        bus.tick(20);
        cmp(scl_line, 1'b0);
        chk_rd(MON_OFF, 32'h13c);
        wait_oe(1'b0);
      end
    join
    chk_rd(MON_OFF, 32'h0c3);
    bus.stop_cond();
  endtask : t_stretch
  // Master clock with divider 1, low count 2, high count 3
  task automatic t_rate();
    int lo;
    int hi;
    wr_reg(CFG_OFF, 32'h0);
    wr_reg(DIV_OFF, 32'h1);
    wr_reg(TIME_OFF, 32'h32);
    wr_reg(CFG_OFF, 32'h1);
    wait_oe(1'b1);
    for (lo = 0; lo < 100 && scl_oe === 1'b1; lo++) @(posedge clk) #1;
    for (hi = 0; hi < 100 && scl_oe === 1'b0; hi++) @(posedge clk) #1;
    cmp(lo, 8);
    // Wire high: 10 in state, 3 to see the release, 1 drive lag
    cmp(hi, 14);
    // Another device pulls SCL low 2 clocks into our high phase
    wait_oe(1'b0);
    bus.tick(5);
    bus.hold_scl(6);
    cmp(scl_oe, 1'b1);
    wr_reg(CFG_OFF, 32'h0);
    wait_oe(1'b0);
  endtask : t_rate
  // Main sequence: reset for three cycles, then each scenario in turn
  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_reset();
    t_disabled();
    t_flags();
    t_qual();
    t_stretch();
    t_rate();
    cmp(bus.n_to, 0);
    end_of_test();
  end
endmodule : i2c_monitor_qualifier_rate_tb
